// file: s16t_pkg.sv
// constants and types shared by the reload/capture timer files
package s16t_pkg;

	// register byte offsets on the slave port
	localparam logic [4:0] S16T_OFS_CONTROL = 5'h00;
	localparam logic [4:0] S16T_OFS_RELOAD_LOW = 5'h04;
	localparam logic [4:0] S16T_OFS_RELOAD_HIGH = 5'h08;
	localparam logic [4:0] S16T_OFS_COUNT_LOW = 5'h0c;
	localparam logic [4:0] S16T_OFS_COUNT_HIGH = 5'h10;
	localparam logic [4:0] S16T_OFS_CLOCK_CONFIG = 5'h14;
	localparam logic [4:0] S16T_OFS_IRQ_ENABLE = 5'h18;

	// timer_control field positions
	localparam int S16T_CTL_HIGH_FLAG = 7;
	localparam int S16T_CTL_LOW_FLAG = 6;
	localparam int S16T_CTL_LOW_IRQ_EN = 5;
	localparam int S16T_CTL_CAPTURE_EN = 4;
	localparam int S16T_CTL_SPLIT = 3;
	localparam int S16T_CTL_RUN = 2;
	localparam int S16T_CTL_CAPTURE_SRC = 1;
	localparam int S16T_CTL_EXT_CLOCK = 0;

	// clock_config_register field positions (index = byte counter)
	localparam int S16T_CFG_LOW_FAST = 0;
	localparam int S16T_CFG_HIGH_FAST = 1;

	// irq enable field position
	localparam int S16T_IRQ_EN_BIT = 0;

	// reset values
	localparam logic [7:0] S16T_RST_CONTROL = 8'h00;
	localparam logic [7:0] S16T_RST_RELOAD = 8'h00;
	localparam logic [7:0] S16T_RST_COUNT = 8'h00;
	localparam logic [1:0] S16T_RST_CLOCK_CONFIG = 2'h0;
	localparam logic S16T_RST_IRQ_ENABLE = 1'b0;

	// clock prescaler counts
	localparam logic [3:0] S16T_SYS_DIV_LAST = 4'hb;
	localparam logic [2:0] S16T_EXT_DIV_LAST = 3'h7;

	typedef enum logic [1:0] {
		S16T_MODE_RELOAD16,
		S16T_MODE_SPLIT8,
		S16T_MODE_CAPTURE16,
		S16T_MODE_CAPTURE8
	} s16t_mode_t;

endpackage : s16t_pkg

// file: s16t_tick_if.sv
// tick and capture-event strobes from the prescaler to the timer core
interface s16t_tick_if;
	logic tick_div12;
	logic tick_ext8;
	logic capture_sof;
	logic capture_lfo;

	modport src (
		output tick_div12,
		output tick_ext8,
		output capture_sof,
		output capture_lfo
	);

	modport dst (
		input tick_div12,
		input tick_ext8,
		input capture_sof,
		input capture_lfo
	);
endinterface : s16t_tick_if

// file: s16t_tick_gen.sv
// pin synchronisers, prescalers and capture-edge pulse generation
module s16t_tick_gen
	import s16t_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	// asynchronous inputs
	input wire logic ext_osc,
	input wire logic usb_sof,
	input wire logic lfo_clock,
	// strobes to the core
	s16t_tick_if.src ticks
);
	import s16t_pkg::*;

	// bit 0 external oscillator, bit 1 sof, bit 2 lfo
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;
	logic [2:0] stable_q;
	logic [2:0] stable_d;
	logic [2:0] rise;
	logic [3:0] sys_div_q;
	logic [2:0] ext_div_q;

	// a change is accepted only once stages two and three agree
	assign stable_d = (~(sync2_q ^ sync3_q) & sync3_q) |
		((sync2_q ^ sync3_q) & stable_q);
	assign rise = stable_d & ~stable_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
			stable_q <= 3'h0;
		end else if (clock_enable) begin
			sync1_q <= {lfo_clock, usb_sof, ext_osc};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			stable_q <= stable_d;
		end
	end

	// system clock divided by 12
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sys_div_q <= 4'h0;
			ticks.tick_div12 <= 1'b0;
		end else if (clock_enable) begin
			ticks.tick_div12 <= (sys_div_q == S16T_SYS_DIV_LAST);
			if (sys_div_q == S16T_SYS_DIV_LAST) begin
				sys_div_q <= 4'h0;
			end else begin
				sys_div_q <= sys_div_q + 4'h1;
			end
		end
	end

	// synchronised external oscillator divided by 8
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_div_q <= 3'h0;
			ticks.tick_ext8 <= 1'b0;
		end else if (clock_enable) begin
			ticks.tick_ext8 <= rise[0] && (ext_div_q == S16T_EXT_DIV_LAST);
			if (rise[0]) begin
				ext_div_q <= ext_div_q + 3'h1;
			end
		end
	end

	// one pulse per accepted rising edge of each capture source
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ticks.capture_sof <= 1'b0;
			ticks.capture_lfo <= 1'b0;
		end else if (clock_enable) begin
			ticks.capture_sof <= rise[1];
			ticks.capture_lfo <= rise[2];
		end
	end

endmodule : s16t_tick_gen

// file: s16t_timer.sv
// top of the 16-bit reload/capture timer with its avalon register slave
////////////////////////////////////////////////////////////////////////////////
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
module s16t_timer
	import s16t_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// clock and capture sources
	input wire logic ext_osc,
	input wire logic usb_sof,
	input wire logic lfo_clock,
	// interrupt request
	output logic timer_irq
);
	import s16t_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers and nets

	logic [7:0] control_q;
	logic [7:0] control_d;
	logic [7:0] reload_low_q;
	logic [7:0] reload_high_q;
	logic [7:0] count_low_q;
	logic [7:0] count_high_q;
	logic [7:0] count_low_d;
	logic [7:0] count_high_d;
	logic [1:0] clock_config_q;
	logic irq_enable_q;
	logic wait_q;
	logic [31:0] readdata_q;
	logic irq_q;

	s16t_mode_t mode;
	logic [1:0] byte_tick;
	logic low_inc;
	logic high_inc;
	logic low_wrap;
	logic high_wrap;
	logic capture_event;
	logic high_set;
	logic low_set;
	logic bus_write;
	logic wr_control;
	logic wr_reload_low;
	logic wr_reload_high;
	logic wr_count_low;
	logic wr_count_high;
	logic wr_clock_config;
	logic wr_irq_enable;

	s16t_tick_if ticks ();

	s16t_tick_gen u_tick_gen (
		.clock(clock),
		.reset_n(reset_n),
		.clock_enable(clock_enable),
		.ext_osc(ext_osc),
		.usb_sof(usb_sof),
		.lfo_clock(lfo_clock),
		.ticks(ticks)
	);

	////////////////////////////////////////////////////////////////////////////
	// mode decode

	always_comb begin
		case ({control_q[S16T_CTL_CAPTURE_EN], control_q[S16T_CTL_SPLIT]})
			2'b00: mode = S16T_MODE_RELOAD16;
			2'b01: mode = S16T_MODE_SPLIT8;
			2'b10: mode = S16T_MODE_CAPTURE16;
			2'b11: mode = S16T_MODE_CAPTURE8;
			default: mode = S16T_MODE_RELOAD16;
		endcase
	end

	// sof or lfo edge, only while capture is enabled
	assign capture_event = control_q[S16T_CTL_CAPTURE_EN] &&
		(control_q[S16T_CTL_CAPTURE_SRC] ? ticks.capture_lfo :
		ticks.capture_sof);

	////////////////////////////////////////////////////////////////////////////
	// per-byte clock source

	// 16-bit modes take the low byte's select for the whole counter
	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_src
			assign byte_tick[b] = clock_config_q[b] ? 1'b1 :
				(control_q[S16T_CTL_EXT_CLOCK] ? ticks.tick_ext8 :
				ticks.tick_div12);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// increments and wraps

	always_comb begin
		low_inc = 1'b0;
		high_inc = 1'b0;
		case (mode)
			S16T_MODE_RELOAD16, S16T_MODE_CAPTURE16: begin
				low_inc = control_q[S16T_CTL_RUN] && byte_tick[0];
				high_inc = low_inc && (count_low_q == 8'hff);
			end
			S16T_MODE_SPLIT8, S16T_MODE_CAPTURE8: begin
				low_inc = byte_tick[0];
				high_inc = control_q[S16T_CTL_RUN] && byte_tick[1];
			end
			default: begin
				low_inc = 1'b0;
				high_inc = 1'b0;
			end
		endcase
	end

	assign low_wrap = low_inc && (count_low_q == 8'hff);
	assign high_wrap = high_inc && (count_high_q == 8'hff);

	////////////////////////////////////////////////////////////////////////////
	// next count

	always_comb begin
		count_low_d = count_low_q;
		count_high_d = count_high_q;
		case (mode)
			S16T_MODE_RELOAD16: begin
				if (high_wrap) begin
					count_low_d = reload_low_q;
					count_high_d = reload_high_q;
				end else begin
					if (low_inc) begin
						count_low_d = count_low_q + 8'h01;
					end
					if (high_inc) begin
						count_high_d = count_high_q + 8'h01;
					end
				end
			end
			S16T_MODE_SPLIT8: begin
				if (low_wrap) begin
					count_low_d = reload_low_q;
				end else if (low_inc) begin
					count_low_d = count_low_q + 8'h01;
				end
				if (high_wrap) begin
					count_high_d = reload_high_q;
				end else if (high_inc) begin
					count_high_d = count_high_q + 8'h01;
				end
			end
			S16T_MODE_CAPTURE16, S16T_MODE_CAPTURE8: begin
				// free running, wraps through zero
				if (low_inc) begin
					count_low_d = count_low_q + 8'h01;
				end
				if (high_inc) begin
					count_high_d = count_high_q + 8'h01;
				end
			end
			default: begin
				count_low_d = count_low_q;
				count_high_d = count_high_q;
			end
		endcase
		// a software write to a count byte overrides counting
		if (wr_count_low) begin
			count_low_d = avs_writedata[7:0];
		end
		if (wr_count_high) begin
			count_high_d = avs_writedata[7:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_low_q <= S16T_RST_COUNT;
			count_high_q <= S16T_RST_COUNT;
		end else if (clock_enable) begin
			count_low_q <= count_low_d;
			count_high_q <= count_high_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reload registers and capture latch

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reload_low_q <= S16T_RST_RELOAD;
			reload_high_q <= S16T_RST_RELOAD;
		end else if (clock_enable) begin
			if (capture_event) begin
				reload_low_q <= count_low_q;
				reload_high_q <= count_high_q;
			end else begin
				if (wr_reload_low) begin
					reload_low_q <= avs_writedata[7:0];
				end
				if (wr_reload_high) begin
					reload_high_q <= avs_writedata[7:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register and flags

	// capture events are reported through the high flag
	assign high_set = high_wrap || capture_event;
	assign low_set = low_wrap;

	always_comb begin
		control_d = wr_control ? avs_writedata[7:0] : control_q;
		// hardware set wins over a clearing write; never self-clears
		control_d[S16T_CTL_HIGH_FLAG] = control_d[S16T_CTL_HIGH_FLAG] ||
			high_set;
		control_d[S16T_CTL_LOW_FLAG] = control_d[S16T_CTL_LOW_FLAG] ||
			low_set;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			control_q <= S16T_RST_CONTROL;
		end else if (clock_enable) begin
			control_q <= control_d;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clock_config_q <= S16T_RST_CLOCK_CONFIG;
			irq_enable_q <= S16T_RST_IRQ_ENABLE;
		end else if (clock_enable) begin
			if (wr_clock_config) begin
				clock_config_q <= {avs_writedata[S16T_CFG_HIGH_FAST],
					avs_writedata[S16T_CFG_LOW_FAST]};
			end
			if (wr_irq_enable) begin
				irq_enable_q <= avs_writedata[S16T_IRQ_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt request

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else if (clock_enable) begin
			irq_q <= irq_enable_q && (control_d[S16T_CTL_HIGH_FLAG] ||
				(control_d[S16T_CTL_LOW_IRQ_EN] &&
				control_d[S16T_CTL_LOW_FLAG]));
		end
	end

	assign timer_irq = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then the request completes

	assign bus_write = avs_write && !wait_q && avs_byteenable[0];
	assign wr_control = bus_write && (avs_address == S16T_OFS_CONTROL);
	assign wr_reload_low = bus_write &&
		(avs_address == S16T_OFS_RELOAD_LOW);
	assign wr_reload_high = bus_write &&
		(avs_address == S16T_OFS_RELOAD_HIGH);
	assign wr_count_low = bus_write && (avs_address == S16T_OFS_COUNT_LOW);
	assign wr_count_high = bus_write &&
		(avs_address == S16T_OFS_COUNT_HIGH);
	assign wr_clock_config = bus_write &&
		(avs_address == S16T_OFS_CLOCK_CONFIG);
	assign wr_irq_enable = bus_write &&
		(avs_address == S16T_OFS_IRQ_ENABLE);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
		end else if (clock_enable) begin
			wait_q <= !(wait_q && (avs_read || avs_write));
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			readdata_q <= 32'h0000_0000;
		end else if (clock_enable) begin
			if (avs_read && wait_q) begin
				case (avs_address)
					S16T_OFS_CONTROL: readdata_q <= {24'h0, control_q};
					S16T_OFS_RELOAD_LOW: readdata_q <= {24'h0, reload_low_q};
					S16T_OFS_RELOAD_HIGH: readdata_q <= {24'h0, reload_high_q};
					S16T_OFS_COUNT_LOW: readdata_q <= {24'h0, count_low_q};
					S16T_OFS_COUNT_HIGH: readdata_q <= {24'h0, count_high_q};
					S16T_OFS_CLOCK_CONFIG: readdata_q <= {30'h0, clock_config_q};
					S16T_OFS_IRQ_ENABLE: readdata_q <= {31'h0, irq_enable_q};
					default: readdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = wait_q;

endmodule : s16t_timer

// file: s16t_timer_checker.sv
// port-level assertions for the reload/capture timer
module s16t_timer_checker (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	// register bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// events and interrupt
	input wire logic usb_sof,
	input wire logic lfo_clock,
	input wire logic timer_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import s16t_pkg::*;
	logic [5:0] ctl_q;
	logic [1:0] cfg_q;
	logic ien_q;
	logic wr_ack;
	logic rd_ack;
	assign wr_ack = avs_write && !avs_waitrequest && clock_enable
		&& avs_byteenable[0];
	assign rd_ack = avs_read && !avs_waitrequest && clock_enable;
	// shadow of the bits that only software writes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q <= 6'h00;
			cfg_q <= 2'h0;
			ien_q <= 1'b0;
		end else if (wr_ack) begin
			if (avs_address == S16T_OFS_CONTROL)
				ctl_q <= avs_writedata[5:0];
			if (avs_address == S16T_OFS_CLOCK_CONFIG)
				cfg_q <= avs_writedata[1:0];
			if (avs_address == S16T_OFS_IRQ_ENABLE)
				ien_q <= avs_writedata[0];
		end
	end
	////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_wait_single: assert property (!avs_waitrequest && clock_enable
		|=> avs_waitrequest) else $error("waitrequest low too long");
	a_answer_bound: assert property ((avs_read || avs_write)
		&& avs_waitrequest |-> ##[1:8] !avs_waitrequest)
		else $error("bus request not answered");
	a_upper_zero: assert property (rd_ack |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_ctl_readback: assert property (rd_ack
		&& avs_address == S16T_OFS_CONTROL |-> avs_readdata[5:0] == ctl_q)
		else $error("control bits read back wrong");
	a_cfg_readback: assert property (rd_ack
		&& avs_address == S16T_OFS_CLOCK_CONFIG
		|-> avs_readdata[7:0] == {6'h00, cfg_q})
		else $error("clock select bits read back wrong");
	a_unmapped_zero: assert property (rd_ack
		&& avs_address > S16T_OFS_IRQ_ENABLE |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_disabled: assert property ((!ien_q) [*2] |-> !timer_irq)
		else $error("interrupt while disabled");
	a_sof_irq: assert property ($rose(usb_sof) && ctl_q[4]
		&& !ctl_q[1] && ien_q |-> ##[2:12] timer_irq)
		else $error("sof capture raised no interrupt");
	a_lfo_irq: assert property ($rose(lfo_clock) && ctl_q[4]
		&& ctl_q[1] && ien_q |-> ##[2:12] timer_irq)
		else $error("lfo capture raised no interrupt");
	c_ctl_read: cover property (rd_ack && avs_address == S16T_OFS_CONTROL);
	c_irq_rise: cover property ($rose(timer_irq));
	c_split_write: cover property (wr_ack && avs_writedata[3]
		&& avs_address == S16T_OFS_CONTROL);
endmodule : s16t_timer_checker

bind s16t_timer s16t_timer_checker chk_u (.clock, .reset_n, .clock_enable,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .usb_sof, .lfo_clock, .timer_irq);

// file: s16t_timer_test.sv
// self-checking testbench for the reload/capture timer
module s16t_timer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import s16t_pkg::*;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} s16t_row_t;
	localparam logic [4:0] ctl = S16T_OFS_CONTROL;
	localparam logic [4:0] rll = S16T_OFS_RELOAD_LOW;
	localparam logic [4:0] rlh = S16T_OFS_RELOAD_HIGH;
	localparam logic [4:0] cnl = S16T_OFS_COUNT_LOW;
	localparam logic [4:0] cnh = S16T_OFS_COUNT_HIGH;
	localparam logic [4:0] cfg = S16T_OFS_CLOCK_CONFIG;
	localparam logic [4:0] ien = S16T_OFS_IRQ_ENABLE;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clock_enable = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_osc = 1'b0;
	logic usb_sof = 1'b0;
	logic lfo_clock = 1'b0;
	logic timer_irq;
	logic [7:0] rd;
	int errors = 0;
	int compares = 0;
	// write then read back, with the value expected
	s16t_row_t rows [10] = '{
		{ctl, 8'h3f, 8'h3f}, {ctl, 8'h00, 8'h00}, {rll, 8'ha5, 8'ha5},
		{rlh, 8'h5a, 8'h5a}, {cnl, 8'h12, 8'h12}, {cnh, 8'h34, 8'h34},
		{cfg, 8'hff, 8'h03}, {ien, 8'hff, 8'h01}, {5'h1c, 8'hff, 8'h00},
		{cfg, 8'h00, 8'h00}};
	always #20 clock = ~clock;
	s16t_timer dut_u (.clock, .reset_n, .clock_enable, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .ext_osc, .usb_sof, .lfo_clock,
		.timer_irq);
	////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int n = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		check(avs_waitrequest, 1'b0);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic w(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask : w
	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hf);
		check(rd, e);
	endtask : rc
	task automatic pulse(input logic low_frequency_oscillator);
		usb_sof <= !low_frequency_oscillator;
		lfo_clock <= low_frequency_oscillator;
		repeat (3) @(posedge clock);
		usb_sof <= 1'b0;
		lfo_clock <= 1'b0;
		@(posedge clock);
	endtask : pulse
	task automatic wait_irq(input int lim);
		for (int n = 0; n < lim && timer_irq !== 1'b1; n++)
			@(posedge clock);
		check(timer_irq, 1'b1);
	endtask : wait_irq
	task automatic complete_run();
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (10000) @(posedge clock);
		check(1'b0, 1'b1);
		complete_run();
	end
	////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 8; i++)
			rc(5'(i * 4), 8'h00);
		foreach (rows[i]) begin
			w(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		bus(1'b1, rll, 8'h00, 4'h0);
		rc(rll, 8'ha5);
		// captures of a stopped count, or of a stopped high byte in split mode
		w(ctl, 8'h10);
		pulse(1'b0);
		wait_irq(20);
		rc(rll, 8'h12);
		rc(rlh, 8'h34);
		rc(ctl, 8'h90);
		w(cnl, 8'h78);
		w(cnh, 8'h56);
		w(ctl, 8'h12);
		pulse(1'b0);
		repeat (12) @(posedge clock);
		check(timer_irq, 1'b0);
		rc(rll, 8'h12);
		pulse(1'b1);
		wait_irq(20);
		rc(rll, 8'h78);
		rc(rlh, 8'h56);
		w(cnh, 8'h9a);
		w(ctl, 8'h1a);
		pulse(1'b1);
		wait_irq(20);
		rc(rlh, 8'h9a);
		// 16-bit reload from 0xfff0 at system clock rate
		w(ctl, 8'h00);
		w(rll, 8'hf0);
		w(rlh, 8'hff);
		w(cfg, 8'h01);
		w(cnl, 8'hfe);
		w(cnh, 8'hff);
		w(ctl, 8'h04);
		wait_irq(300);
		rc(cnh, 8'hff);
		bus(1'b0, cnl, 8'h00, 4'hf);
		check(rd[7:4], 4'hf);
		bus(1'b0, ctl, 8'h00, 4'hf);
		check(rd[7], 1'b1);
		w(ctl, 8'h00);
		w(cnl, 8'hf0);
		w(cnh, 8'h00);
		w(ctl, 8'h04);
		repeat (40) @(posedge clock);
		check(timer_irq, 1'b0);
		rc(ctl, 8'h44);
		w(ctl, 8'h24);
		wait_irq(300);
		// split: low byte runs free, high byte waits for run
		w(ctl, 8'h00);
		w(rll, 8'hfc);
		w(cnl, 8'hfc);
		w(cnh, 8'h77);
		w(ctl, 8'h08);
		repeat (20) @(posedge clock);
		rc(cnh, 8'h77);
		check(timer_irq, 1'b0);
		rc(ctl, 8'h48);
		bus(1'b0, cnl, 8'h00, 4'hf);
		check(rd[7:2], 6'h3f);
		w(ctl, 8'h28);
		wait_irq(20);
		w(rlh, 8'hfe);
		w(cnh, 8'hfe);
		w(cfg, 8'h02);
		w(ctl, 8'h0c);
		wait_irq(20);
		bus(1'b0, ctl, 8'h00, 4'hf);
		check(rd[7], 1'b1);
		// disabling the interrupt drops the request with a flag still set
		w(ien, 8'h00);
		@(posedge clock);
		check(timer_irq, 1'b0);
		// mid-run reset clears the interrupt and read data, raises waitrequest and clears the registers
		reset_n <= 1'b0;
		@(posedge clock);
		check(timer_irq, 1'b0);
		check(avs_waitrequest, 1'b1);
		check(avs_readdata, 32'h0000_0000);
		reset_n <= 1'b1;
		@(posedge clock);
		rc(ctl, 8'h00);
		rc(rlh, 8'h00);
		// prescaled rates: 120 clocks at /12, 80 pin edges at /8
		w(cfg, 8'h00);
		w(ctl, 8'h08);
		w(cnl, 8'h00);
		// a low clock enable freezes the count and its prescaler
		clock_enable <= 1'b0;
		repeat (120) @(posedge clock);
		clock_enable <= 1'b1;
		bus(1'b0, cnl, 8'h00, 4'hf);
		check(rd inside {[8'h00:8'h01]}, 1'b1);
		w(cnl, 8'h00);
		repeat (120) @(posedge clock);
		bus(1'b0, cnl, 8'h00, 4'hf);
		check(rd inside {[8'h09:8'h0b]}, 1'b1);
		w(ctl, 8'h09);
		w(cnl, 8'h00);
		repeat (80) begin
			ext_osc <= 1'b1;
			repeat (2) @(posedge clock);
			ext_osc <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (8) @(posedge clock);
		bus(1'b0, cnl, 8'h00, 4'hf);
		check(rd inside {[8'h09:8'h0b]}, 1'b1);
		complete_run();
	end
endmodule : s16t_timer_test
